// file: src/dcsf_map.svh
// Constants for the L1 data cache snoop and flush block.
// Included by the package and the top module; holds definitions only.
`ifndef DCSF_MAP_SVH
`define DCSF_MAP_SVH

`define DCSF_ADDR_W     8
`define DCSF_IDX_W      2
`define DCSF_TAG_W      6
`define DCSF_LINES      4
`define DCSF_FIDX_W     3
`define DCSF_FIDX_END   3'h4
`define DCSF_POST_W     2
`define DCSF_POST_CLKS  2'h2

`endif

// file: src/dcsf_pkg.sv
// Types shared by the snoop and flush block and its line store.
// Assumes the constant header sits beside it on the include path.
`include "dcsf_map.svh"
`default_nettype none

package dcsf_pkg;

	// Coherency state of one cache line.
	typedef enum logic [1:0] {
		MESI_I = 2'h0,
		MESI_S = 2'h1,
		MESI_E = 2'h2,
		MESI_M = 2'h3
	} dcsf_mesi_t;

	// One line: state and tag.
	typedef struct packed {
		dcsf_mesi_t                mesi;
		logic [`DCSF_TAG_W-1:0]    tag;
	} dcsf_line_t;

	// Kind of external bus cycle.
	typedef enum logic [1:0] {
		BC_READ   = 2'h0,
		BC_WRITE  = 2'h1,
		BC_WRBACK = 2'h2,
		BC_FLACK  = 2'h3
	} dcsf_bus_cmd_t;

	// Address and kind of the running bus cycle.
	typedef struct packed {
		dcsf_bus_cmd_t             cmd;
		logic [`DCSF_ADDR_W-1:0]   addr;
	} dcsf_bus_req_t;

	// Controller states.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ISSUE = 3'h1,
		ST_WAIT  = 3'h2,
		ST_POST  = 3'h3,
		ST_YIELD = 3'h4,
		ST_SCAN  = 3'h5
	} dcsf_state_t;

endpackage

`default_nettype wire

// file: src/dcsf_line_store.sv
// Flip-flop store of line states and tags, one write port, two read ports.
// Assumes the owner never needs two writes in one cycle.
`include "dcsf_map.svh"
`default_nettype none

module dcsf_line_store (
	input  wire logic                    sys_clk,   // Bus clock.
	input  wire logic                    reset_n,   // Async reset, active low.
	input  wire logic                    wr_en,     // Write strobe.
	input  wire logic [`DCSF_IDX_W-1:0]  wr_idx,    // Line written.
	input  wire dcsf_pkg::dcsf_line_t    wr_line,   // Value written.
	input  wire logic [`DCSF_IDX_W-1:0]  a_idx,     // Read port A index.
	output      dcsf_pkg::dcsf_line_t    a_line,    // Read port A line.
	input  wire logic [`DCSF_IDX_W-1:0]  b_idx,     // Read port B index.
	output      dcsf_pkg::dcsf_line_t    b_line,    // Read port B line.
	output      logic                    any_mod    // Some line is modified.
);

	dcsf_pkg::dcsf_line_t line_ff  [`DCSF_LINES];
	dcsf_pkg::dcsf_line_t nxt_line [`DCSF_LINES];

	// Each line keeps its value unless the write port names it.
	for (genvar g = 0; g < `DCSF_LINES; g++) begin : g_line
		always_comb begin
			nxt_line[g] = line_ff[g];
			if (wr_en && wr_idx == `DCSF_IDX_W'(g)) begin
				nxt_line[g] = wr_line;
			end
		end

		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				line_ff[g] <= '{mesi: dcsf_pkg::MESI_I, tag: '0};
			end else begin
				line_ff[g] <= nxt_line[g];
			end
		end
	end

	// Reads are combinational so a lookup and its update share a cycle.
	always_comb begin
		a_line  = line_ff[a_idx];
		b_line  = line_ff[b_idx];
		any_mod = 1'b0;
		for (int i = 0; i < `DCSF_LINES; i++) begin
			any_mod = any_mod | (line_ff[i].mesi == dcsf_pkg::MESI_M);
		end
	end

endmodule

`default_nettype wire

// file: src/dcsf_snoop_flush.sv
// Coherency controller of a write-back L1 data cache: processor accesses,
// inquire snoops, bus back-off and bus yield, and the external flush.
// Assumes all inputs are synchronous to sys_clk and the requester holds
// cpu_req_valid until it sees cpu_done, dropping it in the following cycle.
//
// Notes on behaviour
// - A write hitting a shared line goes out as a bus write cycle.
// - A read-type snoop during a shared-line write leaves the line shared.
// - An unlocked write hitting an exclusive line makes it modified, no bus cycle.
// - Snoops from write strobe until two clocks after its ack wait behind it.
// - A write aborted by back-off or yield is rerun after the snoop.
// - Locked updates go to the bus and keep snoops ordered behind them.
// - Flush requests are ignored from acceptance until the acknowledge completes.
// - Every flush ends with a flush acknowledge bus cycle.
// - An accepted flush request is latched and never dropped.
`include "dcsf_map.svh"
`default_nettype none

module dcsf_snoop_flush (
	input  wire logic                   sys_clk,                   // Bus clock.
	input  wire logic                   reset_n,                   // Async reset.
	input  wire logic                   cpu_req_valid,             // Access held.
	input  wire logic                   cpu_req_write,             // 1 write.
	input  wire logic                   cpu_req_locked,            // Atomic.
	input  wire logic [`DCSF_ADDR_W-1:0] cpu_req_addr,             // Line addr.
	output      logic                   cpu_done,                  // Pulse.
	input  wire logic                   address_hold_request,      // Snoop hold.
	input  wire logic                   external_address_strobe_n, // Snoop strobe.
	input  wire logic                   snoop_invalidate,          // Kill line.
	input  wire logic [`DCSF_ADDR_W-1:0] snoop_addr,               // Snoop addr.
	output      logic                   snoop_hit,                 // Pulse.
	output      logic                   snoop_hit_modified,        // Pulse.
	output      logic                   cycle_start_strobe_n,      // Bus start.
	output      dcsf_pkg::dcsf_bus_req_t bus_req,                  // Cmd, addr.
	input  wire logic                   burst_ready_ack_n,         // Bus ack.
	input  wire logic                   bus_backoff_n,             // Abort.
	input  wire logic                   bus_yield_req,             // Yield.
	input  wire logic                   fill_shared,               // Fill as S.
	input  wire logic                   flush_request_n,           // Purge req.
	output      logic                   flush_busy                 // Flushing.
);

	dcsf_pkg::dcsf_state_t   state_ff, nxt_state;
	dcsf_pkg::dcsf_bus_req_t bus_ff, nxt_bus;
	logic                    strobe_n_ff, nxt_strobe_n;
	logic [`DCSF_POST_W-1:0] post_ff, nxt_post;
	logic [`DCSF_FIDX_W-1:0] fidx_ff, nxt_fidx;
	logic                    flushing_ff, nxt_flushing;
	logic                    fpend_ff, nxt_fpend;
	logic                    spend_ff, nxt_spend;
	logic [`DCSF_ADDR_W-1:0] saddr_ff, nxt_saddr;
	logic                    sinv_ff, nxt_sinv;
	logic                    done_ff, nxt_done;
	logic                    shit_ff, nxt_shit;
	logic                    shitm_ff, nxt_shitm;
	logic                    locked_ff, nxt_locked;

	logic                    st_wr_en;
	logic [`DCSF_IDX_W-1:0]  st_wr_idx;
	dcsf_pkg::dcsf_line_t    st_wr_line;
	logic [`DCSF_IDX_W-1:0]  a_idx;
	dcsf_pkg::dcsf_line_t    a_line;
	dcsf_pkg::dcsf_line_t    b_line;
	logic                    any_mod;
	logic                    take_req, cpu_hit, snp_apply, snp_hit, snp_new;

	// Tag match on a valid line; shared by processor and snoop lookups.
	function automatic logic line_hit(input dcsf_pkg::dcsf_line_t ln,
			input logic [`DCSF_ADDR_W-1:0] addr);
		line_hit = (ln.mesi != dcsf_pkg::MESI_I) &&
			(ln.tag == addr[`DCSF_ADDR_W-1:`DCSF_IDX_W]);
	endfunction

	dcsf_line_store u_store (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.wr_en   (st_wr_en),
		.wr_idx  (st_wr_idx),
		.wr_line (st_wr_line),
		.a_idx   (a_idx),
		.a_line  (a_line),
		.b_idx   (saddr_ff[`DCSF_IDX_W-1:0]),
		.b_line  (b_line),
		.any_mod (any_mod)
	);

	// Port A follows the processor in idle, the scan index while flushing.
	assign a_idx = (state_ff == dcsf_pkg::ST_IDLE) ? cpu_req_addr[`DCSF_IDX_W-1:0] :
		(state_ff == dcsf_pkg::ST_SCAN) ? fidx_ff[`DCSF_IDX_W-1:0] :
		bus_ff.addr[`DCSF_IDX_W-1:0];
	assign cpu_hit  = line_hit(a_line, cpu_req_addr);
	assign snp_hit  = line_hit(b_line, saddr_ff);
	assign snp_new  = address_hold_request && !external_address_strobe_n;
	// Snoops are only applied outside a bus cycle and its two-clock tail,
	// which keeps the internal order equal to the bus order.
	assign snp_apply = spend_ff && (state_ff == dcsf_pkg::ST_IDLE ||
		state_ff == dcsf_pkg::ST_YIELD);
	assign take_req = state_ff == dcsf_pkg::ST_IDLE && !spend_ff && !fpend_ff &&
		cpu_req_valid && !done_ff;

	// Next-state logic for the controller, the latches and the line store.
	always_comb begin
		nxt_state    = state_ff;
		nxt_bus      = bus_ff;
		nxt_strobe_n = 1'b1;
		nxt_post     = post_ff;
		nxt_fidx     = fidx_ff;
		nxt_flushing = flushing_ff;
		nxt_done     = 1'b0;
		nxt_shit     = 1'b0;
		nxt_shitm    = 1'b0;
		nxt_locked   = locked_ff;
		st_wr_en     = 1'b0;
		st_wr_idx    = a_idx;
		st_wr_line   = a_line;
		// A new snoop wins over the clear of the one being applied.
		nxt_spend    = snp_new | (spend_ff & ~snp_apply);
		nxt_saddr    = snp_new ? snoop_addr : saddr_ff;
		nxt_sinv     = snp_new ? snoop_invalidate : sinv_ff;
		// Latched on any cycle it is seen outside a flush, whatever the core is doing.
		nxt_fpend    = fpend_ff | (!flush_request_n && !flushing_ff);
		unique case (state_ff)
			dcsf_pkg::ST_IDLE: begin
				if (snp_apply) begin
					nxt_state = dcsf_pkg::ST_IDLE;
				end else if (fpend_ff) begin
					nxt_fpend    = 1'b0;
					nxt_flushing = 1'b1;
					nxt_fidx     = '0;
					nxt_state    = dcsf_pkg::ST_SCAN;
				end else if (take_req) begin
					nxt_locked   = cpu_req_locked;
					nxt_bus.addr = cpu_req_addr;
					if (!cpu_req_write) begin
						nxt_done    = cpu_hit;
						nxt_bus.cmd = dcsf_pkg::BC_READ;
						nxt_state   = cpu_hit ? dcsf_pkg::ST_IDLE : dcsf_pkg::ST_ISSUE;
					end else if (cpu_hit && !cpu_req_locked &&
							a_line.mesi inside {dcsf_pkg::MESI_E, dcsf_pkg::MESI_M}) begin
						st_wr_en        = 1'b1;
						st_wr_line.mesi = dcsf_pkg::MESI_M;
						nxt_done        = 1'b1;
					end else begin
						nxt_bus.cmd = dcsf_pkg::BC_WRITE;
						nxt_state   = dcsf_pkg::ST_ISSUE;
					end
				end
			end
			dcsf_pkg::ST_ISSUE: begin
				if (bus_yield_req || !bus_backoff_n) begin
					nxt_state = dcsf_pkg::ST_YIELD;
				end else begin
					nxt_strobe_n = 1'b0;
					nxt_state    = dcsf_pkg::ST_WAIT;
				end
			end
			dcsf_pkg::ST_WAIT: begin
				if (!bus_backoff_n) begin
					nxt_state = dcsf_pkg::ST_YIELD;
				end else if (!burst_ready_ack_n) begin
					nxt_state = dcsf_pkg::ST_POST;
					nxt_post  = `DCSF_POST_W'(`DCSF_POST_CLKS - 2'h1);
					unique case (bus_ff.cmd)
						dcsf_pkg::BC_READ: begin
							// A modified victim is kept rather than lost; the read
							// then simply stays uncached.
							st_wr_en   = a_line.mesi != dcsf_pkg::MESI_M;
							st_wr_line = '{mesi: fill_shared ? dcsf_pkg::MESI_S :
								dcsf_pkg::MESI_E,
								tag: bus_ff.addr[`DCSF_ADDR_W-1:`DCSF_IDX_W]};
							nxt_done   = 1'b1;
						end
						dcsf_pkg::BC_WRITE: begin
							nxt_done = 1'b1;
						end
						dcsf_pkg::BC_WRBACK: begin
							st_wr_en        = 1'b1;
							st_wr_line.mesi = dcsf_pkg::MESI_I;
						end
						dcsf_pkg::BC_FLACK: begin
							nxt_flushing = 1'b0;
						end
					endcase
				end
			end
			dcsf_pkg::ST_POST: begin
				if (post_ff == '0) begin
					if (bus_ff.cmd == dcsf_pkg::BC_WRBACK) begin
						nxt_fidx  = fidx_ff + `DCSF_FIDX_W'(1);
						nxt_state = dcsf_pkg::ST_SCAN;
					end else begin
						nxt_state = dcsf_pkg::ST_IDLE;
					end
				end else begin
					nxt_post = post_ff - `DCSF_POST_W'(1);
				end
			end
			dcsf_pkg::ST_YIELD: begin
				if (!spend_ff && !bus_yield_req && bus_backoff_n) begin
					nxt_state = dcsf_pkg::ST_ISSUE;
				end
			end
			dcsf_pkg::ST_SCAN: begin
				if (fidx_ff == `DCSF_FIDX_END) begin
					nxt_bus   = '{cmd: dcsf_pkg::BC_FLACK, addr: '0};
					nxt_state = dcsf_pkg::ST_ISSUE;
				end else if (a_line.mesi == dcsf_pkg::MESI_M) begin
					nxt_bus   = '{cmd: dcsf_pkg::BC_WRBACK,
						addr: {a_line.tag, fidx_ff[`DCSF_IDX_W-1:0]}};
					nxt_state = dcsf_pkg::ST_ISSUE;
				end else begin
					st_wr_en        = 1'b1;
					st_wr_line.mesi = dcsf_pkg::MESI_I;
					nxt_fidx        = fidx_ff + `DCSF_FIDX_W'(1);
				end
			end
			default: begin
				nxt_state = dcsf_pkg::ST_IDLE;
			end
		endcase
		// An inquire never raises a line: M, E and S go to S, or to I when it invalidates.
		if (snp_apply) begin
			st_wr_en   = snp_hit;
			st_wr_idx  = saddr_ff[`DCSF_IDX_W-1:0];
			st_wr_line = '{mesi: sinv_ff ? dcsf_pkg::MESI_I : dcsf_pkg::MESI_S,
				tag: b_line.tag};
			nxt_shit   = snp_hit;
			nxt_shitm  = snp_hit && b_line.mesi == dcsf_pkg::MESI_M;
		end
	end

	// Registers only; every output is one of these flops.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff    <= dcsf_pkg::ST_IDLE;
			bus_ff      <= '{cmd: dcsf_pkg::BC_READ, addr: '0};
			strobe_n_ff <= 1'b1;
			post_ff     <= '0;
			fidx_ff     <= '0;
			flushing_ff <= 1'b0;
			fpend_ff    <= 1'b0;
			spend_ff    <= 1'b0;
			saddr_ff    <= '0;
			sinv_ff     <= 1'b0;
			done_ff     <= 1'b0;
			shit_ff     <= 1'b0;
			shitm_ff    <= 1'b0;
			locked_ff   <= 1'b0;
		end else begin
			state_ff    <= nxt_state;
			bus_ff      <= nxt_bus;
			strobe_n_ff <= nxt_strobe_n;
			post_ff     <= nxt_post;
			fidx_ff     <= nxt_fidx;
			flushing_ff <= nxt_flushing;
			fpend_ff    <= nxt_fpend;
			spend_ff    <= nxt_spend;
			saddr_ff    <= nxt_saddr;
			sinv_ff     <= nxt_sinv;
			done_ff     <= nxt_done;
			shit_ff     <= nxt_shit;
			shitm_ff    <= nxt_shitm;
			locked_ff   <= nxt_locked;
		end
	end

	assign cpu_done             = done_ff;
	assign snoop_hit            = shit_ff;
	assign snoop_hit_modified   = shitm_ff;
	assign cycle_start_strobe_n = strobe_n_ff;
	assign bus_req              = bus_ff;
	assign flush_busy           = flushing_ff;

	// Checks on the coherency and flush sequences.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_shared_write_bus:
		assert property (take_req && cpu_req_write && cpu_hit &&
			a_line.mesi == dcsf_pkg::MESI_S |=> state_ff == dcsf_pkg::ST_ISSUE &&
			bus_ff.cmd == dcsf_pkg::BC_WRITE)
		else $error("Shared-line write did not start a bus write.");
	a_snoop_no_excl:
		assert property (snp_apply && snp_hit |-> st_wr_line.mesi != dcsf_pkg::MESI_E)
		else $error("Snoop promoted a line to exclusive.");
	a_excl_write_local:
		assert property (take_req && cpu_req_write && cpu_hit && !cpu_req_locked &&
			a_line.mesi == dcsf_pkg::MESI_E |=> done_ff && strobe_n_ff &&
			state_ff == dcsf_pkg::ST_IDLE)
		else $error("Exclusive write hit went to the bus.");
	a_snoop_ordered:
		assert property (state_ff inside {dcsf_pkg::ST_ISSUE, dcsf_pkg::ST_WAIT,
			dcsf_pkg::ST_POST} |-> !snp_apply)
		else $error("Snoop applied inside a bus cycle window.");
	a_post_two_clk:
		assert property (state_ff == dcsf_pkg::ST_WAIT && bus_backoff_n &&
			!burst_ready_ack_n |=> (state_ff == dcsf_pkg::ST_POST) [*2] ##1
			state_ff != dcsf_pkg::ST_POST)
		else $error("Post-ack window is not two clocks.");
	a_backoff_rerun:
		assert property (state_ff == dcsf_pkg::ST_WAIT && !bus_backoff_n |=>
			state_ff == dcsf_pkg::ST_YIELD && $stable(bus_ff))
		else $error("Back-off did not hold the cycle for rerun.");
	a_locked_external:
		assert property (take_req && cpu_req_write && cpu_req_locked |=>
			state_ff == dcsf_pkg::ST_ISSUE)
		else $error("Locked write completed without a bus cycle.");
	a_flush_ignored:
		assert property ($rose(fpend_ff) |-> !$past(flushing_ff))
		else $error("Flush request accepted during a flush.");
	a_flush_kept:
		assert property (!flush_request_n && !flushing_ff |=> fpend_ff || flushing_ff)
		else $error("Flush request was dropped.");
	a_ack_ends_flush:
		assert property (state_ff == dcsf_pkg::ST_WAIT && bus_backoff_n &&
			!burst_ready_ack_n && bus_ff.cmd == dcsf_pkg::BC_FLACK |=> !flushing_ff)
		else $error("Flush acknowledge did not end the flush.");
	a_ack_after_wb:
		assert property (!strobe_n_ff && bus_ff.cmd == dcsf_pkg::BC_FLACK |-> !any_mod)
		else $error("Flush acknowledge ran with modified lines left.");

	c_shared_write: cover property (!strobe_n_ff && bus_ff.cmd == dcsf_pkg::BC_WRITE);
	c_snoop_hitm:   cover property (snp_apply && snp_hit && b_line.mesi == dcsf_pkg::MESI_M);
	c_backoff:      cover property (state_ff == dcsf_pkg::ST_WAIT && !bus_backoff_n);
	c_flush_wb:     cover property (!strobe_n_ff && bus_ff.cmd == dcsf_pkg::BC_WRBACK);

endmodule

`default_nettype wire

// file: bench/dcsf_bus_model.sv
// Bus responder model: answers each bus cycle after a chosen wait.
// Assumes one cycle in flight at a time and a one-cycle start strobe.
`default_nettype none

module dcsf_bus_model (
	input  wire logic       sys_clk,              // Bus clock.
	input  wire logic       reset_n,              // Async reset.
	input  wire logic       cycle_start_strobe_n, // Cycle start.
	input  wire logic [1:0] ack_delay,            // Extra wait cycles.
	input  wire logic       backoff_cmd,          // Abort instead of ack.
	output var  logic       burst_ready_ack_n,    // Ack, one cycle.
	output var  logic       bus_backoff_n         // Back-off, one cycle.
);
	timeunit 1ns;
	timeprecision 1ns;

	logic       busy_ff;
	logic [1:0] cnt_ff;

	// Both answer lines rest at their pull-up level outside the answer cycle.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_ff           <= 1'b0;
			cnt_ff            <= 2'h0;
			burst_ready_ack_n <= 1'b1;
			bus_backoff_n     <= 1'b1;
		end else begin
			burst_ready_ack_n <= 1'b1;
			bus_backoff_n     <= 1'b1;
			if (!cycle_start_strobe_n) begin
				busy_ff <= 1'b1;
				cnt_ff  <= ack_delay;
			end else if (busy_ff && cnt_ff == 2'h0) begin
				busy_ff           <= 1'b0;
				bus_backoff_n     <= !backoff_cmd;
				burst_ready_ack_n <= backoff_cmd;
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 2'h1;
			end
		end
	end
endmodule

`default_nettype wire

// file: bench/test_l1_data_cache_snoop_and_flush.sv
// Self-checking bench for the snoop and flush controller.
// Assumes the design sources and the bus model are compiled before it.
`include "dcsf_map.svh"
`default_nettype none

module test_l1_data_cache_snoop_and_flush;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk, reset_n, cpu_req_valid, cpu_req_write, cpu_req_locked, cpu_done;
	logic address_hold_request, external_address_strobe_n, snoop_invalidate;
	logic snoop_hit, snoop_hit_modified, cycle_start_strobe_n, burst_ready_ack_n;
	logic bus_backoff_n, bus_yield_req, fill_shared, flush_request_n, flush_busy;
	logic backoff_cmd, yield_en;
	logic [1:0]              ack_delay;
	logic [7:0]              cpu_req_addr, snoop_addr, a;
	dcsf_pkg::dcsf_bus_req_t bus_req;
	dcsf_pkg::dcsf_bus_req_t seen_q[$], exp_q[$];
	dcsf_pkg::dcsf_line_t    ref_l[`DCSF_LINES];
	int                      err_total, comparisons, hits, hits_m, cyc, ack_cyc, hit_cyc;
	int                      strobe_cyc;

	dcsf_snoop_flush DUT (
		.sys_clk(sys_clk), .reset_n(reset_n), .cpu_req_valid(cpu_req_valid),
		.cpu_req_write(cpu_req_write), .cpu_req_locked(cpu_req_locked),
		.cpu_req_addr(cpu_req_addr), .cpu_done(cpu_done),
		.address_hold_request(address_hold_request),
		.external_address_strobe_n(external_address_strobe_n),
		.snoop_invalidate(snoop_invalidate), .snoop_addr(snoop_addr),
		.snoop_hit(snoop_hit), .snoop_hit_modified(snoop_hit_modified),
		.cycle_start_strobe_n(cycle_start_strobe_n), .bus_req(bus_req),
		.burst_ready_ack_n(burst_ready_ack_n), .bus_backoff_n(bus_backoff_n),
		.bus_yield_req(bus_yield_req), .fill_shared(fill_shared),
		.flush_request_n(flush_request_n), .flush_busy(flush_busy)
	);

	dcsf_bus_model u_bus (
		.sys_clk(sys_clk), .reset_n(reset_n), .cycle_start_strobe_n(cycle_start_strobe_n),
		.ack_delay(ack_delay), .backoff_cmd(backoff_cmd),
		.burst_ready_ack_n(burst_ready_ack_n), .bus_backoff_n(bus_backoff_n)
	);

	// Free-running clock at 100 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Bus cycles, acks and snoop pulses are logged at the edge that samples them.
	always @(posedge sys_clk) begin
		cyc++;
		if (reset_n) begin
			if (cycle_start_strobe_n === 1'b0) begin
				seen_q.push_back(bus_req);
				strobe_cyc = cyc;
			end
			if (burst_ready_ack_n === 1'b0) ack_cyc = cyc;
			if (snoop_hit === 1'b1) begin
				hits++;
				hit_cyc = cyc;
			end
			if (snoop_hit_modified === 1'b1) hits_m++;
		end
	end

	// Random bus yields stall cycle starts, which forces reruns after snoops.
	always @(posedge sys_clk) bus_yield_req <= yield_en && ($urandom_range(0, 3) == 0);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	function automatic logic hit(input logic [7:0] x);
		return ref_l[x[1:0]].mesi != dcsf_pkg::MESI_I && ref_l[x[1:0]].tag == x[7:2];
	endfunction

	task automatic check_bus();
		check(seen_q.size(), exp_q.size(), "bus cycle count");
		foreach (exp_q[i]) if (i < seen_q.size()) check(seen_q[i], exp_q[i], "bus cycle");
		seen_q.delete();
		exp_q.delete();
	endtask

	// One processor access; the reference line table predicts bus traffic and state.
	task automatic cpu(input logic w, input logic lk, input logic [7:0] x, input logic fs);
		int n;
		dcsf_mesi_hold: begin
		end
		if (w && (lk || !hit(x) || ref_l[x[1:0]].mesi == dcsf_pkg::MESI_S))
			exp_q.push_back({dcsf_pkg::BC_WRITE, x});
		else if (w && ref_l[x[1:0]].mesi == dcsf_pkg::MESI_E)
			ref_l[x[1:0]].mesi = dcsf_pkg::MESI_M;
		else if (!w && !hit(x)) begin
			exp_q.push_back({dcsf_pkg::BC_READ, x});
			if (ref_l[x[1:0]].mesi != dcsf_pkg::MESI_M)
				ref_l[x[1:0]] = {fs ? dcsf_pkg::MESI_S : dcsf_pkg::MESI_E, x[7:2]};
		end
		@(posedge sys_clk);
		cpu_req_valid  <= 1'b1;
		cpu_req_write  <= w;
		cpu_req_locked <= lk;
		cpu_req_addr   <= x;
		fill_shared    <= fs;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (cpu_done !== 1'b1 && n < 300);
		check(n < 300, 1'b1, "access done");
		@(posedge sys_clk);
		cpu_req_valid <= 1'b0;
		cpu_req_addr  <= ~x;
		repeat (3) @(posedge sys_clk);
		#1;
		check_bus();
	endtask

	// One snoop from the other master; lines it releases show changing junk.
	task automatic snoop(input logic inv, input logic [7:0] x);
		int  n;
		int  h;
		int  hm;
		logic e;
		logic em;
		e  = hit(x);
		em = e && ref_l[x[1:0]].mesi == dcsf_pkg::MESI_M;
		h  = hits;
		hm = hits_m;
		@(posedge sys_clk);
		address_hold_request      <= 1'b1;
		external_address_strobe_n <= 1'b0;
		snoop_invalidate          <= inv;
		snoop_addr                <= x;
		@(posedge sys_clk);
		external_address_strobe_n <= 1'b1;
		snoop_addr                <= ~x;
		n = 0;
		while (hits == h && n < 30) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		address_hold_request <= 1'b0;
		check(hits - h, e, "snoop hit");
		check(hits_m - hm, em, "snoop hit modified");
		if (e) ref_l[x[1:0]].mesi = inv ? dcsf_pkg::MESI_I : dcsf_pkg::MESI_S;
	endtask

	// External flush: writebacks of modified lines in index order, then one acknowledge.
	task automatic flush();
		int n;
		foreach (ref_l[i]) begin
			if (ref_l[i].mesi == dcsf_pkg::MESI_M)
				exp_q.push_back({dcsf_pkg::BC_WRBACK, ref_l[i].tag, i[1:0]});
			ref_l[i].mesi = dcsf_pkg::MESI_I;
		end
		exp_q.push_back({dcsf_pkg::BC_FLACK, 8'h00});
		@(posedge sys_clk);
		flush_request_n <= 1'b0;
		n = 0;
		while (flush_busy !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check(flush_busy, 1'b1, "flush started");
		repeat (2) @(posedge sys_clk);
		flush_request_n <= 1'b1;
		n = 0;
		while (flush_busy !== 1'b0 && n < 200) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		repeat (8) @(posedge sys_clk);
		#1;
		check(flush_busy, 1'b0, "second flush");
		check_bus();
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog sized well beyond the longest expected run.
	initial begin
		#200000;
		err_total++;
		$display("mismatch at %0t: watchdog expired", $time);
		results();
	end

	initial begin
		reset_n                   = 1'b0;
		cpu_req_valid             = 1'b0;
		cpu_req_write             = 1'b0;
		cpu_req_locked            = 1'b0;
		cpu_req_addr              = 8'h00;
		address_hold_request      = 1'b0;
		external_address_strobe_n = 1'b1;
		snoop_invalidate          = 1'b0;
		snoop_addr                = 8'h00;
		fill_shared               = 1'b0;
		flush_request_n           = 1'b1;
		backoff_cmd               = 1'b0;
		yield_en                  = 1'b0;
		ack_delay                 = 2'h0;
		foreach (ref_l[i]) ref_l[i] = '0;
		void'($urandom(80));
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		cpu(1'b0, 1'b0, 8'h05, 1'b1);
		cpu(1'b0, 1'b0, 8'h0a, 1'b0);
		cpu(1'b1, 1'b0, 8'h05, 1'b0);
		cpu(1'b1, 1'b0, 8'h0a, 1'b0);
		// A read snoop inside the write window waits until after the ack.
		ack_delay <= 2'h3;
		fork
			cpu(1'b1, 1'b0, 8'h05, 1'b0);
			begin
				wait (cycle_start_strobe_n === 1'b0);
				snoop(1'b0, 8'h05);
			end
		join
		check(hit_cyc - ack_cyc >= 2, 1'b1, "snoop order");
		cpu(1'b1, 1'b0, 8'h05, 1'b0);
		// A backed-off write is rerun only after the snoop pending behind it.
		// The snoop is raised inside the write so that it waits for the back-off.
		backoff_cmd <= 1'b1;
		exp_q.push_back({dcsf_pkg::BC_WRITE, 8'h05});
		fork
			cpu(1'b1, 1'b0, 8'h05, 1'b0);
			begin
				wait (cycle_start_strobe_n === 1'b0);
				fork
					snoop(1'b0, 8'h0a);
					begin
						wait (bus_backoff_n === 1'b0);
						backoff_cmd <= 1'b0;
					end
				join
			end
		join
		check(hit_cyc < strobe_cyc, 1'b1, "rerun after snoop");
		cpu(1'b0, 1'b0, 8'h0f, 1'b0);
		cpu(1'b1, 1'b1, 8'h0f, 1'b0);
		cpu(1'b1, 1'b0, 8'h0f, 1'b0);
		snoop(1'b1, 8'h0f);
		yield_en <= 1'b1;
		for (int k = 0; k < 30; k++) begin
			@(posedge sys_clk);
			a         <= {5'h00, 3'($urandom_range(0, 7))};
			ack_delay <= 2'($urandom_range(0, 3));
			#1;
			case ($urandom_range(0, 3))
				0: cpu(1'b0, 1'b0, a, 1'($urandom_range(0, 1)));
				1: cpu(1'b1, 1'b0, a, 1'b0);
				2: cpu(1'b1, 1'b1, a, 1'b0);
				default: snoop(1'($urandom_range(0, 1)), a);
			endcase
		end
		cpu(1'b0, 1'b0, 8'h02, 1'b0);
		cpu(1'b1, 1'b0, 8'h02, 1'b0);
		flush();
		snoop(1'b0, 8'h05);
		flush();
		results();
	end
endmodule

`default_nettype wire
